// File: rtl/fplc_params.svh
// Purpose: Constants for the fractional loop control block
// Assumes: One system clock at 25 MHz; all loop signals are sampled on it
// Notes:   Timing counts are in clk_sys cycles or lock timer ticks
`ifndef FPLC_PARAMS_SVH
`define FPLC_PARAMS_SVH

`define FPLC_CLK_MHZ          25
`define FPLC_FRAC_STEPS       16
`define FPLC_INT_W            12
`define FPLC_FRAC_W           4
`define FPLC_DIV_W            11
`define FPLC_LTIME_W          3
`define FPLC_FILT_W           2
`define FPLC_SYNC_N           6
`define FPLC_TMR_W            16
`define FPLC_LTIME_STEP_TICKS 16'h0008
`define FPLC_SETTLE_NS        640
`define FPLC_SETTLE_CYCLES    ((`FPLC_SETTLE_NS * `FPLC_CLK_MHZ + 999) / 1000)
`define FPLC_SETTLE_W         8
`define FPLC_FILT_HI_LIMIT    12'h200
`define FPLC_FILT_MID_LIMIT   12'h040

`endif

// File: rtl/fplc_pkg.sv
// Purpose: Types shared by the fractional loop control block
// Assumes: Constants come from fplc_params.svh
// Notes:   Control and loop configuration travel as packed structs
`include "fplc_params.svh"
package fplc_pkg;

  // =====================================================================
  // Reference source selection
  typedef enum logic [1:0] {
    FPLC_REF_FIRST,
    FPLC_REF_SECOND,
    FPLC_REF_GENERIC,
    FPLC_REF_SPARE
  } fplc_ref_type;

  // =====================================================================
  // Software control bits
  typedef struct packed {
    logic                        loop_enable_bit;
    fplc_ref_type                reference_source_select;
    logic [`FPLC_DIV_W-1:0]      ref_divider_field;
    logic [`FPLC_INT_W-1:0]      ratio_integer_part;
    logic [`FPLC_FRAC_W-1:0]     ratio_fraction_part;
    logic [`FPLC_LTIME_W-1:0]    lock_time_select;
    logic                        fast_wake_select;
    logic                        gate_ignore_lock;
    logic [`FPLC_FILT_W-1:0]     filter_override_field;
    logic                        converter_bypass_field;
  } fplc_ctrl_type;

  // =====================================================================
  // Configuration driven into the analog loop core
  typedef struct packed {
    logic                        core_reset;
    logic [`FPLC_INT_W-1:0]      ratio_integer_part;
    logic [`FPLC_FRAC_W-1:0]     ratio_fraction_part;
    logic                        fractional_mode;
    logic [`FPLC_FILT_W-1:0]     filter_setting;
    logic                        converter_bypass;
  } fplc_core_cfg_type;

  // Gate controller states
  typedef enum logic [1:0] {
    FPLC_GATE_OFF,
    FPLC_GATE_STARTUP,
    FPLC_GATE_RUN
  } fplc_gate_type;

endpackage : fplc_pkg

// File: rtl/fplc_ref_divider.sv
// Purpose: Divides the sampled second reference source
// Assumes: src_level is already synchronised to clk_sys
// Notes:   Output toggles every div+1 rising edges of the source
`timescale 1ns/1ps
`include "fplc_params.svh"
module fplc_ref_divider (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire logic                   src_level,
  input  wire logic [`FPLC_DIV_W-1:0] div_field,
  output logic                        div_out
);
  import fplc_pkg::*;

  logic                   prev_q;
  logic [`FPLC_DIV_W-1:0] cnt_q;
  logic                   out_q;
  logic                   rise;

  // Rising edge of the sampled source
  assign rise    = src_level & ~prev_q;
  assign div_out = out_q;

  // =====================================================================
  // Edge history
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= src_level;
    end
  end

  // Half period of div+1 edges gives a total ratio of 2*(div+1)
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (rise) begin
      if (cnt_q >= div_field) begin
        cnt_q <= '0;
        out_q <= ~out_q;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule : fplc_ref_divider

// File: rtl/fplc_top.sv
// Purpose: Control around a fractional digital phase locked loop
// Assumes: The loop core is outside; its clock and lock come in as pins
// Notes:   The six source, timer, loop output and lock pins pass two flip-flops before logic reads them
`timescale 1ns/1ps
`include "fplc_params.svh"
module fplc_top #(
  parameter logic [`FPLC_TMR_W-1:0] LTIME_STEP_TICKS = `FPLC_LTIME_STEP_TICKS
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  input  wire fplc_pkg::fplc_ctrl_type    ctrl,
  input  wire logic                       lock_fail_clear,
  input  wire logic                       timeout_clear,
  input  wire logic                       lock_fail_irq_en,
  input  wire logic                       timeout_irq_en,
  input  wire logic                       first_reference_source,
  input  wire logic                       second_reference_source,
  input  wire logic                       generic_reference_source,
  input  wire logic                       lock_timer_clock,
  input  wire logic                       raw_loop_output,
  input  wire logic                       loop_core_lock,
  output logic                            loop_reference_clock,
  output fplc_pkg::fplc_core_cfg_type     loop_core_cfg,
  output logic                            gated_pll_clock,
  output logic                            loop_locked_status,
  output logic                            lock_fail_flag,
  output logic                            lock_timer_expired_flag,
  output logic                            irq
);
  import fplc_pkg::*;

  // =====================================================================
  // Declarations
  fplc_ctrl_type              ctrl_q;
  fplc_core_cfg_type          cfg_q;
  logic [`FPLC_SYNC_N-1:0]    pin_raw;
  logic [`FPLC_SYNC_N-1:0]    sync1_q;
  logic [`FPLC_SYNC_N-1:0]    sync2_q;
  logic                       ref0_s;
  logic                       ref1_s;
  logic                       gen_s;
  logic                       tmr_clk_s;
  logic                       raw_s;
  logic                       core_lock_s;
  logic                       ref1_div;
  logic                       ref_q;
  logic                       enable_q;
  logic                       start;
  logic                       ratio_update;
  logic                       tmr_prev_q;
  logic                       tmr_tick;
  logic [`FPLC_TMR_W-1:0]     tmr_cnt_q;
  logic                       tmr_run_q;
  logic                       tmr_done_q;
  logic                       tmr_done_pulse;
  logic [`FPLC_SETTLE_W-1:0]  settle_q;
  logic                       lock_d;
  logic                       lock_q;
  logic                       raw_prev_q;
  logic                       raw_seen_q;
  fplc_gate_type              gate_q;
  logic                       gate_open;
  logic                       gated_q;
  logic                       fail_q;
  logic                       tto_q;
  logic                       irq_q;

  localparam logic [`FPLC_SETTLE_W-1:0] SETTLE_CYCLES = `FPLC_SETTLE_W'(`FPLC_SETTLE_CYCLES);

  // Automatic filter choice from the integer ratio
  function automatic logic [`FPLC_FILT_W-1:0] auto_filter(input logic [`FPLC_INT_W-1:0] ratio);
    if (ratio >= `FPLC_FILT_HI_LIMIT) begin
      auto_filter = 2'h2;
    end else if (ratio >= `FPLC_FILT_MID_LIMIT) begin
      auto_filter = 2'h1;
    end else begin
      auto_filter = 2'h0;
    end
  endfunction : auto_filter

  // =====================================================================
  // Pin synchronisers
  assign pin_raw = {loop_core_lock, raw_loop_output, lock_timer_clock,
                    generic_reference_source, second_reference_source,
                    first_reference_source};

  // Two flip-flops per pin; only the second stage is read
  generate
    for (genvar i = 0; i < `FPLC_SYNC_N; i++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
        end else begin
          sync1_q[i] <= pin_raw[i];
          sync2_q[i] <= sync1_q[i];
        end
      end
    end
  endgenerate

  assign ref0_s      = sync2_q[0];
  assign ref1_s      = sync2_q[1];
  assign gen_s       = sync2_q[2];
  assign tmr_clk_s   = sync2_q[3];
  assign raw_s       = sync2_q[4];
  assign core_lock_s = sync2_q[5];

  // =====================================================================
  // Control staging
  // Software bits are registered once before any loop logic reads them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl;
    end
  end

  // Enable history gives the start event
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= ctrl_q.loop_enable_bit;
    end
  end

  assign start        = ctrl_q.loop_enable_bit & ~enable_q;
  assign ratio_update = enable_q & ctrl_q.loop_enable_bit &
                        ({ctrl_q.ratio_integer_part, ctrl_q.ratio_fraction_part} !=
                         {cfg_q.ratio_integer_part, cfg_q.ratio_fraction_part});

  // =====================================================================
  // Reference selection
  fplc_ref_divider u_ref_div (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .src_level (ref1_s),
    .div_field (ctrl_q.ref_divider_field),
    .div_out   (ref1_div)
  );

  // Mux of the three sources; the spare code falls back to the first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ref_q <= 1'b0;
    end else begin
      unique case (ctrl_q.reference_source_select)
        FPLC_REF_FIRST:   ref_q <= ref0_s;
        FPLC_REF_SECOND:  ref_q <= ref1_div;
        FPLC_REF_GENERIC: ref_q <= gen_s;
        FPLC_REF_SPARE:   ref_q <= ref0_s;
      endcase
    end
  end

  // =====================================================================
  // Loop core configuration
  // Ratio is applied live; the core multiplies by int+1+frac/16
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q            <= '0;
      cfg_q.core_reset <= 1'b1;
    end else begin
      cfg_q.core_reset          <= ~ctrl_q.loop_enable_bit;
      cfg_q.ratio_integer_part  <= ctrl_q.ratio_integer_part;
      cfg_q.ratio_fraction_part <= ctrl_q.ratio_fraction_part;
      cfg_q.fractional_mode     <= (ctrl_q.ratio_fraction_part != 4'h0);
      cfg_q.converter_bypass    <= ctrl_q.converter_bypass_field;
      if (ctrl_q.filter_override_field != 2'h0) begin
        cfg_q.filter_setting <= ctrl_q.filter_override_field;
      end else begin
        cfg_q.filter_setting <= auto_filter(ctrl_q.ratio_integer_part);
      end
    end
  end

  // =====================================================================
  // Lock timer
  assign tmr_tick = tmr_clk_s & ~tmr_prev_q;

  // Timer clock edge history
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tmr_prev_q <= 1'b0;
    end else begin
      tmr_prev_q <= tmr_clk_s;
    end
  end

  // Loads on start or ratio update, counts down on timer ticks
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tmr_cnt_q  <= '0;
      tmr_run_q  <= 1'b0;
      tmr_done_q <= 1'b0;
    end else if (!ctrl_q.loop_enable_bit || ctrl_q.lock_time_select == 3'h0) begin
      tmr_cnt_q  <= '0;
      tmr_run_q  <= 1'b0;
      tmr_done_q <= 1'b0;
    end else if (start || ratio_update) begin
      tmr_cnt_q  <= `FPLC_TMR_W'(ctrl_q.lock_time_select * LTIME_STEP_TICKS);
      tmr_run_q  <= 1'b1;
      tmr_done_q <= 1'b0;
    end else if (tmr_run_q && tmr_tick) begin
      if (tmr_cnt_q <= `FPLC_TMR_W'(1)) begin
        tmr_cnt_q  <= '0;
        tmr_run_q  <= 1'b0;
        tmr_done_q <= 1'b1;
      end else begin
        tmr_cnt_q <= tmr_cnt_q - 1'b1;
      end
    end
  end

  assign tmr_done_pulse = tmr_run_q & tmr_tick & (tmr_cnt_q <= `FPLC_TMR_W'(1)) &
                          ctrl_q.loop_enable_bit & (ctrl_q.lock_time_select != 3'h0) &
                          ~start & ~ratio_update;

  // =====================================================================
  // Lock status
  // Settle window after a ratio update keeps lock cleared
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      settle_q <= '0;
    end else if (!ctrl_q.loop_enable_bit) begin
      settle_q <= '0;
    end else if (ratio_update) begin
      settle_q <= SETTLE_CYCLES;
    end else if (settle_q != '0) begin
      settle_q <= settle_q - 1'b1;
    end
  end

  // Lock source: timer when a lock time is chosen, else loop status
  always_comb begin
    lock_d = 1'b0;
    if (ctrl_q.loop_enable_bit && !ratio_update && settle_q == '0) begin
      if (ctrl_q.lock_time_select != 3'h0) begin
        lock_d = tmr_done_q;
      end else begin
        lock_d = core_lock_s;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
    end
  end

  // =====================================================================
  // Output clock gate
  // With fast wake, startup ends at the first sampled edge of the raw loop output
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      raw_prev_q <= 1'b0;
      raw_seen_q <= 1'b0;
    end else begin
      raw_prev_q <= raw_s;
      if (!ctrl_q.loop_enable_bit) begin
        raw_seen_q <= 1'b0;
      end else if (raw_s && !raw_prev_q) begin
        raw_seen_q <= 1'b1;
      end
    end
  end

  // Off, waiting for the first edge (fast wake), timer done or lock, then running
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gate_q <= FPLC_GATE_OFF;
    end else if (!ctrl_q.loop_enable_bit) begin
      gate_q <= FPLC_GATE_OFF;
    end else begin
      unique case (gate_q)
        FPLC_GATE_OFF: begin
          gate_q <= FPLC_GATE_STARTUP;
        end
        FPLC_GATE_STARTUP: begin
          if (ctrl_q.fast_wake_select) begin
            if (raw_seen_q) begin
              gate_q <= FPLC_GATE_RUN;
            end
          end else if (ctrl_q.lock_time_select != 3'h0) begin
            if (tmr_done_q) begin
              gate_q <= FPLC_GATE_RUN;
            end
          end else if (lock_q) begin
            gate_q <= FPLC_GATE_RUN;
          end
        end
        FPLC_GATE_RUN: begin
          gate_q <= FPLC_GATE_RUN;
        end
      endcase
    end
  end

  assign gate_open = (gate_q == FPLC_GATE_RUN) && ctrl_q.loop_enable_bit &&
                     (ctrl_q.gate_ignore_lock || lock_q);

  // Gated copy of the sampled loop output
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gated_q <= 1'b0;
    end else begin
      gated_q <= gate_open & raw_s;
    end
  end

  // =====================================================================
  // Flags and request; a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fail_q <= 1'b0;
    end else if (lock_q && !lock_d) begin
      fail_q <= 1'b1;
    end else if (lock_fail_clear) begin
      fail_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tto_q <= 1'b0;
    end else if (tmr_done_pulse) begin
      tto_q <= 1'b1;
    end else if (timeout_clear) begin
      tto_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (fail_q & lock_fail_irq_en) | (tto_q & timeout_irq_en);
    end
  end

  // =====================================================================
  // Outputs straight from flip-flops
  assign loop_reference_clock    = ref_q;
  assign loop_core_cfg           = cfg_q;
  assign gated_pll_clock         = gated_q;
  assign loop_locked_status      = lock_q;
  assign lock_fail_flag          = fail_q;
  assign lock_timer_expired_flag = tto_q;
  assign irq                     = irq_q;

endmodule : fplc_top

// File: sim/fplc_props.sv
// Purpose: Concurrent checks on the ports of the loop control block
// Assumes: One clk_sys domain, rst_b asynchronous and active low
// Notes:   Bound into every fplc_top instance at the foot of this file
`timescale 1ns/1ps
module fplc_props (
  input wire logic                        clk_sys,
  input wire logic                        rst_b,
  input wire fplc_pkg::fplc_ctrl_type     ctrl,
  input wire logic                        lock_fail_clear,
  input wire logic                        lock_fail_irq_en,
  input wire logic                        timeout_irq_en,
  input wire fplc_pkg::fplc_core_cfg_type loop_core_cfg,
  input wire logic                        gated_pll_clock,
  input wire logic                        loop_locked_status,
  input wire logic                        lock_fail_flag,
  input wire logic                        lock_timer_expired_flag,
  input wire logic                        irq
);
  import fplc_pkg::*;

  // ======================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_off_core_reset : assert property ((!ctrl.loop_enable_bit)[*2] |=> loop_core_cfg.core_reset)
    else $error("Core left running while disabled");
  a_on_core_run : assert property ((ctrl.loop_enable_bit)[*2] |=> !loop_core_cfg.core_reset)
    else $error("Core held in reset while enabled");
  a_off_gate_lock : assert property ((!ctrl.loop_enable_bit)[*3] |=> !gated_pll_clock && !loop_locked_status)
    else $error("Output or lock active while disabled");
  a_frac_mode_sel : assert property (loop_core_cfg.fractional_mode == (loop_core_cfg.ratio_fraction_part != 4'h0))
    else $error("Fractional mode does not match fraction field");
  a_ratio_on_fly : assert property (($stable(ctrl.ratio_integer_part) && $stable(ctrl.ratio_fraction_part))[*3]
    |=> loop_core_cfg.ratio_integer_part == $past(ctrl.ratio_integer_part)
    && loop_core_cfg.ratio_fraction_part == $past(ctrl.ratio_fraction_part))
    else $error("Ratio not applied to loop core");
  a_filter_override : assert property (($stable(ctrl.filter_override_field) && ctrl.filter_override_field != 2'h0)[*2]
    |=> loop_core_cfg.filter_setting == $past(ctrl.filter_override_field))
    else $error("Filter override ignored");
  a_conv_bypass : assert property ($stable(ctrl.converter_bypass_field)[*2]
    |=> loop_core_cfg.converter_bypass == $past(ctrl.converter_bypass_field))
    else $error("Converter bypass not applied");
  a_fail_on_fall : assert property ($fell(loop_locked_status) |-> ##[0:2] lock_fail_flag)
    else $error("Lock fall did not set fail flag");
  a_fail_sticky : assert property (lock_fail_flag && !lock_fail_clear && !$past(lock_fail_clear) |=> lock_fail_flag)
    else $error("Fail flag cleared without a clear");
  a_irq_follows : assert property (irq == $past((lock_fail_flag && lock_fail_irq_en)
    || (lock_timer_expired_flag && timeout_irq_en)))
    else $error("Interrupt request does not follow flags");
  a_gate_needs_lock : assert property ((!ctrl.gate_ignore_lock)[*4] ##0 gated_pll_clock
    |-> $past(loop_locked_status) || $past(loop_locked_status, 2) || $past(loop_locked_status, 3))
    else $error("Gated output running without lock");

  // Main scenarios reached
  c_gate_run : cover property ($rose(gated_pll_clock));
  c_fail_set : cover property ($rose(lock_fail_flag));
  c_tmo_set  : cover property ($rose(lock_timer_expired_flag));
  c_irq_set  : cover property ($rose(irq));
endmodule : fplc_props

bind fplc_top fplc_props u_props (.clk_sys, .rst_b, .ctrl, .lock_fail_clear, .lock_fail_irq_en, .timeout_irq_en,
  .loop_core_cfg, .gated_pll_clock, .loop_locked_status, .lock_fail_flag, .lock_timer_expired_flag, .irq);

// File: sim/fplc_tb.sv
// Purpose: Self-checking bench for the loop control block
// Assumes: Bench makes all pin clocks from clk_sys; lock pin driven by hand
// Notes:   One lock timer tick per lock time step keeps timer mode short
`timescale 1ns/1ps
module testbench;
  import fplc_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, lock_fail_clear = 1'b0, timeout_clear = 1'b0;
  logic lock_fail_irq_en = 1'b0, timeout_irq_en = 1'b0, first_reference_source = 1'b0;
  logic second_reference_source = 1'b0, generic_reference_source = 1'b0, lock_timer_clock = 1'b0;
  logic raw_loop_output = 1'b0, loop_core_lock = 1'b0;
  logic loop_reference_clock, gated_pll_clock, loop_locked_status, lock_fail_flag, lock_timer_expired_flag, irq;
  fplc_ctrl_type     ctrl = '0;
  fplc_core_cfg_type loop_core_cfg;
  logic [7:0]        tick = 8'h00;
  int                checks = 0, mismatches = 0, gcnt = 0, rcnt = 0;

  fplc_top #(.LTIME_STEP_TICKS(16'h0001)) dut_u (.clk_sys, .rst_b, .ctrl, .lock_fail_clear, .timeout_clear,
    .lock_fail_irq_en, .timeout_irq_en, .first_reference_source, .second_reference_source,
    .generic_reference_source, .lock_timer_clock, .raw_loop_output, .loop_core_lock, .loop_reference_clock,
    .loop_core_cfg, .gated_pll_clock, .loop_locked_status, .lock_fail_flag, .lock_timer_expired_flag, .irq);

  // ======================================================================
  // Clock, pin clocks and edge counters
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tick                     <= tick + 8'h01;
    raw_loop_output          <= ~raw_loop_output;
    first_reference_source   <= tick[1];
    second_reference_source  <= tick[1];
    generic_reference_source <= tick[2];
    lock_timer_clock         <= tick[3];
  end
  always @(posedge gated_pll_clock) gcnt++;
  always @(posedge loop_reference_clock) rcnt++;

  // ======================================================================
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic enable(input logic v);
    @(posedge clk_sys);
    ctrl.loop_enable_bit <= v;
  endtask : enable
  function automatic logic pick(input int k);
    case (k)
      0: return loop_locked_status;
      1: return lock_fail_flag;
      2: return lock_timer_expired_flag;
      default: return irq;
    endcase
  endfunction : pick
  // Bounded wait for a status output to reach a level
  task automatic wait_lvl(input int k, input int lim, input logic v);
    for (int i = 0; i < lim && pick(k) !== v; i++) cyc(1);
  endtask : wait_lvl
  // Rising edges of gated output (g=1) or reference (g=0) over n cycles
  task automatic rises(input logic g, input int n, output int c);
    int s;
    s = g ? gcnt : rcnt;
    cyc(n);
    c = (g ? gcnt : rcnt) - s;
  endtask : rises
  task automatic pulse(input logic tmo);
    @(posedge clk_sys);
    if (tmo) timeout_clear <= 1'b1; else lock_fail_clear <= 1'b1;
    @(posedge clk_sys);
    timeout_clear   <= 1'b0;
    lock_fail_clear <= 1'b0;
    cyc(3);
  endtask : pulse

  // ======================================================================
  // Scenarios
  task automatic t_normal();
    int c;
    enable(1'b1);
    rises(1'b1, 30, c);
    check(loop_core_cfg.core_reset, 1'b0, "core reset after enable");
    check(c, 0, "gated edges before lock");
    check(loop_locked_status, 1'b0, "lock before core lock");
    check(loop_core_cfg.fractional_mode, 1'b0, "integer mode");
    check(loop_core_cfg.filter_setting, 2'h1, "auto filter mid range");
    @(posedge clk_sys);
    loop_core_lock <= 1'b1;
    wait_lvl(0, 10, 1'b1);
    check(loop_locked_status, 1'b1, "lock follows core");
    rises(1'b1, 20, c);
    check(c inside {[9:11]}, 1'b1, "gated runs once locked");
  endtask : t_normal

  task automatic t_ratio();
    @(posedge clk_sys);
    lock_fail_irq_en         <= 1'b1;
    ctrl.ratio_integer_part  <= 12'h0fe;
    ctrl.ratio_fraction_part <= 4'h3;
    wait_lvl(0, 6, 1'b0);
    check(loop_locked_status, 1'b0, "lock cleared on ratio write");
    cyc(8);
    check(loop_locked_status, 1'b0, "lock held low while settling");
    check(lock_fail_flag, 1'b1, "fail flag on lock fall");
    check(irq, 1'b1, "irq on fail flag");
    check({loop_core_cfg.ratio_integer_part, loop_core_cfg.ratio_fraction_part}, 16'h0fe3, "new ratio");
    check(loop_core_cfg.fractional_mode, 1'b1, "fractional mode");
    wait_lvl(0, 30, 1'b1);
    check(loop_locked_status, 1'b1, "lock set again");
    @(posedge clk_sys);
    lock_fail_irq_en <= 1'b0;
    cyc(3);
    check(irq, 1'b0, "irq masked");
    check(lock_fail_flag, 1'b1, "flag sticky");
    pulse(1'b0);
    check(lock_fail_flag, 1'b0, "flag cleared by one");
  endtask : t_ratio

  task automatic t_drop();
    int c;
    @(posedge clk_sys);
    loop_core_lock <= 1'b0;
    cyc(6);
    rises(1'b1, 20, c);
    check(c, 0, "gated stops on lock loss");
    @(posedge clk_sys);
    ctrl.gate_ignore_lock <= 1'b1;
    cyc(6);
    rises(1'b1, 20, c);
    check(c inside {[9:11]}, 1'b1, "gated runs in bypass");
    pulse(1'b0);
  endtask : t_drop

  task automatic t_timer();
    int c;
    enable(1'b0);
    cyc(5);
    @(posedge clk_sys);
    ctrl.gate_ignore_lock <= 1'b0;
    ctrl.lock_time_select <= 3'h2;
    timeout_irq_en        <= 1'b1;
    enable(1'b1);
    cyc(8);
    check(lock_timer_expired_flag, 1'b0, "timeout too early");
    wait_lvl(2, 120, 1'b1);
    check(lock_timer_expired_flag, 1'b1, "timeout after lock time");
    cyc(2);
    check(loop_locked_status, 1'b1, "lock from timer");
    check(irq, 1'b1, "irq on timeout");
    rises(1'b1, 20, c);
    check(c inside {[9:11]}, 1'b1, "gated runs after countdown");
    pulse(1'b1);
    check(lock_timer_expired_flag, 1'b0, "timeout cleared");
  endtask : t_timer

  task automatic t_wake();
    int c;
    enable(1'b0);
    cyc(5);
    @(posedge clk_sys);
    ctrl.lock_time_select <= 3'h0;
    ctrl.fast_wake_select <= 1'b1;
    ctrl.gate_ignore_lock <= 1'b1;
    enable(1'b1);
    cyc(12);
    rises(1'b1, 20, c);
    check(c inside {[9:11]}, 1'b1, "gated opens at startup end");
    check(loop_locked_status, 1'b0, "no lock in fast wake");
    @(posedge clk_sys);
    ctrl.filter_override_field  <= 2'h3;
    ctrl.converter_bypass_field <= 1'b1;
    cyc(3);
    check(loop_core_cfg.filter_setting, 2'h3, "filter override");
    check(loop_core_cfg.converter_bypass, 1'b1, "converter bypass");
  endtask : t_wake

  task automatic t_refs();
    int c;
    int exp[4] = '{16, 4, 8, 16};
    for (int k = 0; k < 4; k++) begin
      enable(1'b0);
      @(posedge clk_sys);
      ctrl.reference_source_select <= fplc_ref_type'(k);
      enable(1'b1);
      cyc(10);
      rises(1'b0, 64, c);
      check(c inside {[exp[k] - 1:exp[k] + 1]}, 1'b1, "reference rate");
    end
  endtask : t_refs

  // ======================================================================
  // Verdict and run control
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  initial begin
    #(40 * 5000);
    mismatches++;
    test_done();
  end

  initial begin
    ctrl.ratio_integer_part = 12'h0ff;
    ctrl.ref_divider_field  = 11'h001;
    cyc(2);
    check(loop_core_cfg.core_reset, 1'b1, "core reset in reset");
    check({gated_pll_clock, loop_locked_status, lock_fail_flag, irq}, 4'h0, "outputs in reset");
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_normal();
    t_ratio();
    t_drop();
    t_timer();
    t_wake();
    t_refs();
    test_done();
  end
endmodule : testbench
